// ==== verilog/msl_loader.sv ====
// state loader for monitor activation and deactivation
module msl_loader
  import msl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic activate_in, // pulse: activating exit starts
  input wire logic [63:0] vm_control_structure_ptr_in, // current structure pointer
  input wire logic [63:0] monitor_segment_base_in, // monitor segment base
  input wire logic [31:0] hdr_data_in, // header word read data
  input wire logic hdr_ack_in, // header word valid
  input wire logic [31:0] cr0_in, // state before the exit
  input wire logic [63:0] cr3_in,
  input wire logic [31:0] cr4_in,
  input wire logic lma_in,
  input wire logic [63:0] idt_base_in,
  input wire logic deact_in, // pulse: deactivating entry
  input wire logic in_smm_in,
  input wire logic entry_smm_in,
  input wire logic [63:0] exec_ptr_in,
  input wire logic [63:0] vmx_on_region_pointer_ptr_in,
  input wire logic smx_in,
  output logic hdr_rd_out,
  output logic [63:0] hdr_addr_out,
  output logic [63:0] xfer_ptr_out,
  output logic xfer_ptr_we_out,
  output logic busy_out,
  output logic done_out,
  output logic [31:0] cr0_out,
  output logic [63:0] cr3_out,
  output logic [31:0] cr4_out,
  output logic [31:0] dr7_out,
  output logic [63:0] dbgctl_out,
  output logic [NSEG-1:0][15:0] seg_sel_out, // cs, ss, ds, es, fs, gs
  output logic [NSEG-1:0][31:0] seg_ar_out,
  output logic [63:0] seg_base_out,
  output logic [31:0] seg_limit_out,
  output logic [15:0] ldt_sel_out,
  output logic ldt_unusable_out,
  output logic [63:0] gdt_base_out,
  output logic [15:0] gdt_limit_out,
  output logic [63:0] idt_base_out,
  output logic [15:0] idt_limit_out,
  output logic [63:0] ip_out,
  output logic [63:0] sp_out,
  output logic [63:0] flags_out,
  output logic active_state_out,
  output logic sti_block_out,
  output logic movss_block_out,
  output logic nmi_block_out,
  output logic smi_block_out,
  output logic pend_dbg_out,
  output logic lme_out,
  output logic lma_out,
  output logic tlb_flush_out,
  output logic msr_list_skip_out,
  output logic deact_done_out,
  output logic deact_fail_out
);
  logic rst_b; // synchronised reset
  msl_state_t state_reg, state_next;
  logic [31:0] hdr_reg [HDR_WORDS]; // fetched header words
  logic [2:0] idx_reg; // word being fetched
  logic [63:0] base_reg; // base latched at start
  logic [63:0] idt_reg; // idt base latched at start
  logic [15:0] code_sel; // from selector calc
  logic [15:0] data_sel;

  msl_rst_sync u_rst (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .rst_b_out(rst_b)
  );

  msl_sel_calc u_sel (
    .hdr_sel_in(hdr_reg[HDR_CSSEL]),
    .code_sel_out(code_sel),
    .data_sel_out(data_sel)
  );

  // long-mode feature read from features word bit zero
  wire feat_long = hdr_reg[HDR_FEAT][FEAT_LONG_BIT] & HAS_LONG;
  wire [63:0] hdr_ofs = {59'h0, idx_reg, 2'h0};
  wire last_word = idx_reg == 3'(HDR_WORDS - 1);
  wire [31:0] pt_sum = base_reg[31:0] + hdr_reg[HDR_PTOFS];
  wire [31:0] gd_sum = base_reg[31:0] + hdr_reg[HDR_GBASE];
  wire [31:0] ip_sum = base_reg[31:0] + hdr_reg[HDR_IPOFS];
  wire [31:0] sp_sum = base_reg[31:0] + hdr_reg[HDR_SPOFS];
  // control zero: fixed ones, cache bits carried
  wire [31:0] cr0_keep = cr0_in & ((32'h1 << CR0_CD) | (32'h1 << CR0_NW));
  wire [31:0] cr0_set = (32'h1 << CR0_PG) | (32'h1 << CR0_NE) | (32'h1 << CR0_ET)
    | (32'h1 << CR0_MP) | (32'h1 << CR0_PE);
  wire [31:0] cr0_new = cr0_keep | cr0_set;
  // page table base, only 31:12 and 4:3 survive
  wire [63:0] cr3_new = {32'h0, pt_sum[31:12], 7'h0,
    hdr_reg[HDR_PTOFS][4:3], 3'h0};
  // control four: clear four, set paging bits
  wire pse_new = ~feat_long & HAS_PSE;
  wire [31:0] cr4_clr = ~((32'h1 << CR4_MCE) | (32'h1 << CR4_PGE)
    | (32'h1 << CR4_PAE) | (32'h1 << CR4_PSE));
  wire [31:0] cr4_new = (cr4_in & cr4_clr) | ({31'h0, feat_long} << CR4_PAE)
    | ({31'h0, pse_new} << CR4_PSE);
  // paging-relevant change detection
  wire cr3_chg = cr3_new[63:5] != cr3_in[63:5];
  wire pae_chg = cr4_new[CR4_PAE] != cr4_in[CR4_PAE];
  wire pse_chg = cr4_new[CR4_PSE] != cr4_in[CR4_PSE];
  wire lma_chg = feat_long != lma_in;
  // pse has no effect when long mode held before and after
  wire pse_hit = pse_chg & ~(lma_in & feat_long);
  wire flush_need = cr3_chg | pae_chg | pse_hit | lma_chg;
  // deactivation failure cases
  wire deact_bad = ~in_smm_in | entry_smm_in | (exec_ptr_in != vmx_on_region_pointer_ptr_in);
  wire fetch_go = state_reg == ST_FETCH;
  wire word_take = state_reg == ST_WAIT && hdr_ack_in;
  wire load_go = state_reg == ST_LOAD;

  // next-state decode
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (activate_in) state_next = ST_FETCH;
      ST_FETCH: state_next = ST_WAIT;
      ST_WAIT: begin
        if (hdr_ack_in) state_next = last_word ? ST_LOAD : ST_FETCH;
      end
      ST_LOAD: state_next = ST_IDLE;
    endcase
  end

  // sequencer: pointer save, then header words in order
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      base_reg <= 64'h0;
      idt_reg <= 64'h0;
      xfer_ptr_out <= 64'h0;
      xfer_ptr_we_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      xfer_ptr_we_out <= 1'b0;
      if (state_reg == ST_IDLE && activate_in) begin
        // saved first, ahead of any pointer update downstream
        xfer_ptr_out <= vm_control_structure_ptr_in;
        xfer_ptr_we_out <= 1'b1;
        base_reg <= monitor_segment_base_in;
        idt_reg <= idt_base_in;
        idx_reg <= 3'h0;
      end
      if (word_take) idx_reg <= idx_reg + 3'h1;
    end
  end

  // header words land in the local array
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < HDR_WORDS; i++) hdr_reg[i] <= 32'h0;
    end else if (word_take) begin
      hdr_reg[idx_reg] <= hdr_data_in;
    end
  end

  // header read port, one word per request
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      hdr_rd_out <= 1'b0;
      hdr_addr_out <= 64'h0;
      busy_out <= 1'b0;
    end else begin
      hdr_rd_out <= fetch_go;
      if (fetch_go) hdr_addr_out <= base_reg + hdr_ofs;
      busy_out <= state_next != ST_IDLE;
    end
  end

  // control and descriptor-table state, all in one edge
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cr0_out <= 32'h0;
      cr3_out <= 64'h0;
      cr4_out <= 32'h0;
      dr7_out <= 32'h0;
      dbgctl_out <= 64'h0;
      gdt_base_out <= 64'h0;
      gdt_limit_out <= 16'h0;
      idt_base_out <= 64'h0;
      idt_limit_out <= 16'h0;
      ldt_sel_out <= 16'h0;
      ldt_unusable_out <= 1'b0;
    end else if (load_go) begin
      // single commit keeps partial state invisible
      cr0_out <= cr0_new;
      cr3_out <= cr3_new;
      cr4_out <= cr4_new;
      dr7_out <= DR7_VAL;
      dbgctl_out <= DBGCTL_VAL;
      gdt_base_out <= {32'h0, gd_sum};
      gdt_limit_out <= hdr_reg[HDR_GLIM][15:0];
      idt_base_out <= idt_reg;
      idt_limit_out <= SEL_ZERO;
      ldt_sel_out <= SEL_ZERO;
      ldt_unusable_out <= 1'b1;
    end
  end

  // pointers, flags and long-mode enables
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ip_out <= 64'h0;
      sp_out <= 64'h0;
      flags_out <= FLAGS_VAL;
      active_state_out <= 1'b0;
      lme_out <= 1'b0;
      lma_out <= 1'b0;
      seg_base_out <= 64'h0;
      seg_limit_out <= 32'h0;
    end else if (load_go) begin
      ip_out <= {32'h0, ip_sum};
      sp_out <= {32'h0, sp_sum};
      flags_out <= FLAGS_VAL;
      active_state_out <= 1'b1;
      lme_out <= feat_long;
      lma_out <= feat_long;
      seg_base_out <= 64'h0;
      seg_limit_out <= SEG_LIMIT;
    end
  end

  // per-segment selector and access rights
  for (genvar s = 0; s < NSEG; s++) begin : g_seg
    // code segment is entry zero, the rest are data
    wire is_code = s == 0;
    wire [15:0] sel_val = is_code ? code_sel : data_sel;
    wire [3:0] type_val = is_code ? TYPE_CODE : TYPE_DATA;
    wire l_bit = is_code & feat_long;
    wire db_bit = is_code ? ~feat_long : 1'b1;
    wire [31:0] ar_val = {15'h0, 1'b0, 1'b1, db_bit, l_bit, 5'h0,
      1'b1, 2'h0, 1'b1, type_val};
    always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
        seg_sel_out[s] <= 16'h0;
        seg_ar_out[s] <= 32'h0;
      end else if (load_go) begin
        seg_sel_out[s] <= sel_val;
        seg_ar_out[s] <= ar_val;
      end
    end
  end

  // event blocking, translation flush and completion strobes
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      sti_block_out <= 1'b0;
      movss_block_out <= 1'b0;
      nmi_block_out <= 1'b0;
      smi_block_out <= 1'b0;
      pend_dbg_out <= 1'b0;
      tlb_flush_out <= 1'b0;
      msr_list_skip_out <= 1'b0;
      done_out <= 1'b0;
      deact_done_out <= 1'b0;
      deact_fail_out <= 1'b0;
    end else begin
      tlb_flush_out <= load_go & flush_need;
      // the list is never walked, the skip output tells downstream logic so
      msr_list_skip_out <= load_go;
      done_out <= load_go;
      deact_done_out <= deact_in & ~busy_out & ~deact_bad;
      deact_fail_out <= deact_in & ~busy_out & deact_bad;
      if (load_go) begin
        sti_block_out <= 1'b0;
        movss_block_out <= 1'b0;
        pend_dbg_out <= 1'b0;
        nmi_block_out <= 1'b1;
        smi_block_out <= 1'b1;
      end else if (deact_in && !busy_out && !deact_bad) begin
        // guest block bit ignored, safer mode decides
        smi_block_out <= smx_in;
      end
    end
  end

  // checks on the loader's own outputs
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b);

  a_ptr_save_first: assert property (
    state_reg == ST_IDLE && activate_in |=> xfer_ptr_we_out && !done_out
      && xfer_ptr_out == $past(vm_control_structure_ptr_in))
    else $error("pointer not saved first");
  a_cr0_fixed: assert property (
    done_out |-> cr0_out[CR0_PG] && cr0_out[CR0_PE] && cr0_out[CR0_NE]
      && cr0_out[28:6] == 23'h0)
    else $error("control zero value wrong");
  a_cr3_form: assert property (
    done_out |-> cr3_out[11:5] == 7'h0 && cr3_out[2:0] == 3'h0
      && cr3_out[63:32] == 32'h0)
    else $error("page table base bits wrong");
  a_cr4_paging: assert property (
    done_out |-> cr4_out[CR4_PAE] == lma_out && !cr4_out[CR4_MCE]
      && cr4_out[CR4_PSE] == (!lma_out && HAS_PSE))
    else $error("control four paging bits wrong");
  a_sel_nonzero: assert property (
    done_out |-> seg_sel_out[0] != 16'h0 && seg_sel_out[1] != 16'h0
      && seg_sel_out[0][2:0] == 3'h0)
    else $error("selector zero after load");
  a_block_set: assert property (
    done_out |-> nmi_block_out && smi_block_out && !sti_block_out
      && !pend_dbg_out && flags_out == FLAGS_VAL)
    else $error("blocking state wrong");
  a_deact_fail: assert property (
    deact_in && !busy_out && !in_smm_in |=> deact_fail_out && !deact_done_out)
    else $error("deactivation outside smm not failed");
  a_deact_smi: assert property (
    deact_in && !busy_out && !deact_bad && !activate_in |=> smi_block_out == $past(smx_in))
    else $error("smi block not from safer mode");
  a_load_bound: assert property (
    state_reg == ST_LOAD |=> done_out && msr_list_skip_out && state_reg == ST_IDLE)
    else $error("load not committed in one edge");
  a_long_same: assert property (
    done_out |-> lme_out == lma_out && seg_ar_out[0][AR_L] == lma_out)
    else $error("long mode bits disagree");

  c_activate: cover property (done_out && lma_out);
  c_flush: cover property (tlb_flush_out);
  c_deact_ok: cover property (deact_done_out && smi_block_out);
  c_deact_bad: cover property (deact_fail_out);
endmodule : msl_loader

// ==== verilog/msl_pkg.sv ====
package msl_pkg;
  // header word indices, byte offset is four times index
  localparam int HDR_WORDS = 8;
  localparam logic [2:0] HDR_REV = 3'h0;
  localparam logic [2:0] HDR_FEAT = 3'h1;
  localparam logic [2:0] HDR_GLIM = 3'h2;
  localparam logic [2:0] HDR_GBASE = 3'h3;
  localparam logic [2:0] HDR_CSSEL = 3'h4;
  localparam logic [2:0] HDR_IPOFS = 3'h5;
  localparam logic [2:0] HDR_SPOFS = 3'h6;
  localparam logic [2:0] HDR_PTOFS = 3'h7;
  localparam int FEAT_LONG_BIT = 0;
  // control zero bit positions
  localparam int CR0_PG = 31;
  localparam int CR0_CD = 30;
  localparam int CR0_NW = 29;
  localparam int CR0_NE = 5;
  localparam int CR0_ET = 4;
  localparam int CR0_MP = 1;
  localparam int CR0_PE = 0;
  // control four bit positions
  localparam int CR4_PSE = 4;
  localparam int CR4_PAE = 5;
  localparam int CR4_MCE = 6;
  localparam int CR4_PGE = 7;
  // implementation features
  localparam logic HAS_LONG = 1'h1;
  localparam logic HAS_PSE = 1'h1;
  // fixed load values
  localparam logic [31:0] DR7_VAL = 32'h0000_0400;
  localparam logic [63:0] DBGCTL_VAL = 64'h0;
  localparam logic [15:0] SEL_STEP = 16'h0008;
  localparam logic [15:0] SEL_ZERO = 16'h0000;
  localparam logic [31:0] SEG_LIMIT = 32'h0FFF_FFFF;
  localparam logic [63:0] FLAGS_VAL = 64'h0000_0000_0000_0002;
  localparam logic [3:0] TYPE_CODE = 4'hB;
  localparam logic [3:0] TYPE_DATA = 4'h3;
  // access-rights field positions
  localparam int AR_S = 4;
  localparam int AR_P = 7;
  localparam int AR_L = 13;
  localparam int AR_DB = 14;
  localparam int AR_G = 15;
  localparam int AR_UNUSABLE = 16;
  localparam int NSEG = 6;
  // loader states
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_LOAD} msl_state_t;
endpackage : msl_pkg

// ==== verilog/msl_rst_sync.sv ====
// two-stage release of the asynchronous reset
module msl_rst_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic rst_b_out
);
  logic meta_reg; // first stage, read only by second
  // assert at once, release after two edges
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b0;
      rst_b_out <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      rst_b_out <= meta_reg;
    end
  end
endmodule : msl_rst_sync

// ==== verilog/msl_sel_calc.sv ====
// selector derivation from the header selector word
module msl_sel_calc
  import msl_pkg::*;
(
  input wire logic [31:0] hdr_sel_in,
  output logic [15:0] code_sel_out,
  output logic [15:0] data_sel_out
);
  wire [15:0] raw_sel = {hdr_sel_in[15:3], 3'h0}; // high half ignored
  wire [15:0] sum_sel = raw_sel == SEL_ZERO ? SEL_STEP : raw_sel;
  wire [15:0] dat_sum = sum_sel + SEL_STEP; // wraps when code is FFF8H
  assign code_sel_out = sum_sel;
  assign data_sel_out = dat_sum == SEL_ZERO ? SEL_STEP : dat_sum;
endmodule : msl_sel_calc

// ==== tb/monitor_activation_state_loader_test.sv ====
// self-checking bench for the monitor activation state loader
module monitor_activation_state_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  import msl_pkg::*;
  // design inputs, all defined at time zero
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic activate_in = 1'b0, deact_in = 1'b0, hdr_ack_in = 1'b0;
  logic [63:0] vm_control_structure_ptr_in = 64'h0000_0042_0000_1000;
  logic [63:0] monitor_segment_base_in = 64'hABCD_0000_1000_0000; // high half set on purpose
  logic [63:0] idt_base_in = 64'h0000_7777_0000_1100;
  logic [63:0] cr3_in = '0, exec_ptr_in = 64'h0000_0000_0000_0055, vmx_on_region_pointer_ptr_in = '0;
  logic [31:0] hdr_data_in = '0, cr0_in = 32'h6001_0008, cr4_in = '0;
  logic lma_in = 1'b0, in_smm_in = 1'b0, entry_smm_in = 1'b0, smx_in = 1'b0;
  // design outputs
  logic hdr_rd_out, xfer_ptr_we_out, busy_out, done_out, ldt_unusable_out;
  logic active_state_out, sti_block_out, movss_block_out, nmi_block_out, smi_block_out;
  logic pend_dbg_out, lme_out, lma_out, tlb_flush_out, msr_list_skip_out;
  logic deact_done_out, deact_fail_out;
  logic [63:0] hdr_addr_out, xfer_ptr_out, cr3_out, dbgctl_out, seg_base_out;
  logic [63:0] gdt_base_out, idt_base_out, ip_out, sp_out, flags_out;
  logic [31:0] cr0_out, cr4_out, dr7_out, seg_limit_out;
  logic [15:0] ldt_sel_out, gdt_limit_out, idt_limit_out;
  logic [NSEG-1:0][15:0] seg_sel_out;
  logic [NSEG-1:0][31:0] seg_ar_out;
  // bench bookkeeping
  int bad_count = 0, total_checks = 0, cycles = 0, ack_delay = 0, dly = 0;
  logic [31:0] hdr_mem [8];
  logic [2:0] rd_idx = '0;
  logic pend = 1'b0, smi_exp = 1'b0;

  msl_loader msl_loader_inst (.*);

  // free-running core clock, 50 ns period
  always #25 clk_in = ~clk_in;

  // header memory: answers each read after ack_delay cycles
  always @(negedge clk_in) begin
    hdr_ack_in = 1'b0;
    hdr_data_in = ~hdr_data_in; // released bus flips every cycle, never holding the old word steady
    if (hdr_rd_out) begin
      pend = 1'b1;
      dly = ack_delay;
      rd_idx = hdr_addr_out[4:2];
      chk("hdr_addr_hi", monitor_segment_base_in[63:5], hdr_addr_out[63:5]);
    end
    if (pend) begin
      if (dly == 0) begin
        hdr_ack_in = 1'b1;
        hdr_data_in = hdr_mem[rd_idx];
        pend = 1'b0;
      end else begin
        dly = dly - 1;
      end
    end
  end

  // hang guard, well above the hundred or fewer cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles >= 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one activating exit; flush is the expected translation invalidate
  task automatic activate(input string tn, input logic feat, input logic [31:0] sel,
      input logic [63:0] c3, input logic [31:0] c4, input logic lm, input logic flush,
      input int slow);
    logic [31:0] s, arc, ard;
    logic [15:0] cs, ds;
    logic [31:0] c0p;
    int n;
    c0p = cr0_out; // value left by any earlier activation
    hdr_mem = '{32'h0, {31'h0, feat}, 32'h1234_00FF, 32'h0000_0200, sel, 32'h0000_1000,
      32'h0000_2000, 32'h0003_0FFF};
    ack_delay = slow;
    cr3_in = c3;
    cr4_in = c4;
    lma_in = lm;
    // expected selectors, wrap case folds to 0008H
    cs = sel[15:0] & 16'hFFF8;
    if (cs == 16'h0) cs = 16'h0008;
    ds = cs + 16'h0008;
    if (ds == 16'h0) ds = 16'h0008;
    arc = 32'h0000_809B | ({31'h0, feat} << 13) | ({31'h0, !feat} << 14);
    ard = 32'h0000_C093;
    s = monitor_segment_base_in[31:0] + 32'h0003_0FFF;
    activate_in = 1'b1;
    @(negedge clk_in);
    activate_in = 1'b0;
    deact_in = 1'b1; // must be refused while busy
    chk("xfer_ptr_we", 1'b1, xfer_ptr_we_out);
    chk("xfer_ptr", vm_control_structure_ptr_in, xfer_ptr_out);
    chk("busy", 1'b1, busy_out);
    n = 0;
    while (done_out !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      deact_in = 1'b0;
      chk("deact_ignored", 2'b00, {deact_done_out, deact_fail_out});
      if (done_out !== 1'b1) chk("cr0_not_early", c0p, cr0_out);
      n++;
    end
    chk("done", 1'b1, done_out);
    chk("cr0", 32'h8000_0033 | (cr0_in & 32'h6000_0000), cr0_out);
    chk("cr3", {32'h0, s[31:12], 7'h0, 2'b11, 3'h0}, cr3_out);
    chk("cr4", (c4 & ~32'h0000_00F0) | ({31'h0, feat} << 5) | ({31'h0, !feat} << 4),
      cr4_out);
    chk("dr7", 32'h0000_0400, dr7_out);
    chk("dbgctl", 64'h0, dbgctl_out);
    for (int i = 0; i < NSEG; i++) begin
      chk("seg_sel", (i == 0) ? cs : ds, seg_sel_out[i]);
      chk("seg_ar", (i == 0) ? arc : ard, seg_ar_out[i]);
    end
    chk("seg_base", 64'h0, seg_base_out);
    chk("seg_limit", 32'h0FFF_FFFF, seg_limit_out);
    chk("ldt", {16'h0, 1'b1}, {ldt_sel_out, ldt_unusable_out});
    chk("gdt_base", {32'h0, monitor_segment_base_in[31:0] + 32'h0000_0200}, gdt_base_out);
    chk("gdt_limit", 16'h00FF, gdt_limit_out);
    chk("idt", {idt_base_in, 16'h0}, {idt_base_out, idt_limit_out});
    chk("ip", {32'h0, monitor_segment_base_in[31:0] + 32'h0000_1000}, ip_out);
    chk("sp", {32'h0, monitor_segment_base_in[31:0] + 32'h0000_2000}, sp_out);
    chk("flags", 64'h2, flags_out);
    chk("active", 1'b1, active_state_out);
    chk("blocking", 5'b00110, {sti_block_out, movss_block_out, nmi_block_out, smi_block_out,
      pend_dbg_out});
    chk("efer", {feat, feat}, {lme_out, lma_out});
    chk("tlb_flush", flush, tlb_flush_out);
    chk("msr_skip", 1'b1, msr_list_skip_out);
    smi_exp = 1'b1;
    @(negedge clk_in);
    chk("pulses_end", 3'b000, {done_out, tlb_flush_out, msr_list_skip_out});
    $display("test %s done", tn);
  endtask : activate

  // one deactivating entry; deact_in stays high so calls run back to back
  task automatic deact(input logic smm, input logic esmm, input logic eq, input logic safer_mode_operation);
    logic ok;
    ok = smm & !esmm & eq;
    in_smm_in = smm;
    entry_smm_in = esmm;
    smx_in = safer_mode_operation;
    vmx_on_region_pointer_ptr_in = eq ? exec_ptr_in : ~exec_ptr_in;
    deact_in = 1'b1;
    @(negedge clk_in);
    chk("deact_done", ok, deact_done_out);
    chk("deact_fail", !ok, deact_fail_out);
    if (ok) smi_exp = safer_mode_operation;
    chk("smi_block", smi_exp, smi_block_out);
  endtask : deact

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // main sequence, inputs change on falling edges only
  initial begin
    repeat (10) @(negedge clk_in);
    chk("reset_flags", 64'h2, flags_out);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_in);
    // wrapping selector, 32-bit mode, paging base changes
    activate("activation_wrap", 1'b0, 32'hFFFF_FFFF, 64'h0, 32'hFFFF_FFFF, 1'b0, 1'b1, 0);
    // zero selector, long mode, only a masked large-page change: no flush
    activate("activation_long", 1'b1, 32'h0, 64'h1003_0018, 32'h0000_0030, 1'b1, 1'b0, 2);
    // success, each failure cause, then success under safer mode
    deact(1'b1, 1'b0, 1'b1, 1'b0);
    deact(1'b0, 1'b0, 1'b1, 1'b1);
    deact(1'b1, 1'b1, 1'b1, 1'b1);
    deact(1'b1, 1'b0, 1'b0, 1'b1);
    deact(1'b1, 1'b0, 1'b1, 1'b1);
    deact_in = 1'b0;
    @(negedge clk_in);
    $display("test deactivation done");
    print_verdict();
  end
endmodule : monitor_activation_state_loader_test
